// ===== core/slwd_pkg.sv
// package: register map, field layout and timing constants of the link watchdog block
`default_nettype none
package slwd_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_VCO    = 10'h10b;
  localparam logic [9:0] IDX_SYNC   = 10'h120;
  localparam logic [9:0] IDX_TEST   = 10'h121;
  localparam logic [9:0] IDX_WDCFG  = 10'h124;
  localparam logic [9:0] IDX_CTRL   = 10'h130;
  localparam logic [9:0] IDX_STATUS = 10'h131;
  localparam logic [9:0] IDX_COUNT  = 10'h132;

  // reset values
  localparam logic [7:0] RST_VCO   = 8'h00;
  localparam logic [7:0] RST_SYNC  = 8'h01;
  localparam logic [7:0] RST_TEST  = 8'h00;
  localparam logic [7:0] RST_WDCFG = 8'h00;
  localparam logic [7:0] RST_CTRL  = 8'h00;

  // field positions
  localparam int VCO_LOW_BIT    = 0;
  localparam int SYNC_REQ_BIT   = 0;
  localparam int TEST_LSB       = 0;
  localparam int TEST_W         = 5;
  localparam int WD_PLL_BIT     = 7;
  localparam int WD_RATE_LSB    = 4;
  localparam int WD_THR_LSB     = 0;
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_ENC_BIT   = 1;
  localparam int ST_LINK_UP_BIT = 0;
  localparam int ST_SYNC_BIT    = 1;
  localparam int ST_CRC_BIT     = 2;
  localparam int ST_EXP_BIT     = 3;

  // watchdog arithmetic
  localparam int          WD_W       = 33;
  localparam logic [32:0] WD_UP_STEP = 33'h000000080;
  localparam logic [32:0] WD_THR_1   = 33'h000020000;
  localparam logic [32:0] WD_THR_2   = 33'h000080000;
  localparam logic [32:0] WD_THR_3   = 33'h100000000;
  localparam logic [32:0] WD_THR_4   = 33'h000800000;
  localparam logic [32:0] WD_DEC_0   = 33'h000000001;
  localparam logic [32:0] WD_DEC_1   = 33'h000000002;
  localparam logic [32:0] WD_DEC_2   = 33'h000000008;
  localparam logic [32:0] WD_DEC_3   = 33'h000000010;

  // receive test modes
  typedef enum logic [4:0] {
    SLWD_TEST_NORMAL = 5'h00,
    SLWD_TEST_PRBS7  = 5'h01,
    SLWD_TEST_PRBS9  = 5'h02,
    SLWD_TEST_PRBS15 = 5'h03,
    SLWD_TEST_PRBS31 = 5'h04
  } slwd_test_t;
endpackage
`default_nettype wire

// ===== core/slwd_top.sv
// top: wishbone register file, sync request, test select and link watchdog
`timescale 1ns/1ps
`default_nettype none

module slwd_top (
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST,
  input  wire logic                   CYC_I,
  input  wire logic                   STB_I,
  input  wire logic                   WE_I,
  input  wire logic [11:2]            ADR_I,
  input  wire logic [3:0]             SEL_I,
  input  wire logic [31:0]            DAT_I,
  output logic      [31:0]            DAT_O,
  output logic                        ACK_O,
  input  wire logic                   EB_RELEASED,
  input  wire logic                   CRC_FAULT,
  input  wire logic                   LINK_SYNC_N,
  output logic                        SYNC_N,
  output logic                        VCO_LOW_RANGE,
  output slwd_pkg::slwd_test_t        TEST_MODE,
  output logic                        LINK_ENABLE,
  output logic                        LINK_ENCODING,
  output logic                        SERDES_RX_RESET,
  output logic                        SERDES_PLL_RESET
);
  import slwd_pkg::*;

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0]      vco_reg;
  logic [7:0]      sync_reg;
  logic [7:0]      test_reg;
  logic [7:0]      wdcfg_reg;
  logic [7:0]      ctrl_reg;
  logic            expired;
  logic [WD_W-1:0] wd_count;

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  wire req      = CYC_I & STB_I & ~ACK_O;
  wire wr_lane0 = req & WE_I & SEL_I[0];
  wire hit_vco  = (ADR_I == IDX_VCO);
  wire hit_sync = (ADR_I == IDX_SYNC);
  wire hit_test = (ADR_I == IDX_TEST);
  wire hit_wd   = (ADR_I == IDX_WDCFG);
  wire hit_ctrl = (ADR_I == IDX_CTRL);
  wire hit_st   = (ADR_I == IDX_STATUS);
  wire hit_cnt  = (ADR_I == IDX_COUNT);

  wire wr_vco  = wr_lane0 & hit_vco;
  wire wr_sync = wr_lane0 & hit_sync;
  wire wr_test = wr_lane0 & hit_test;
  wire wr_wd   = wr_lane0 & hit_wd;
  wire wr_ctrl = wr_lane0 & hit_ctrl;
  wire clr_exp = wr_lane0 & hit_st & DAT_I[ST_EXP_BIT];

  // status: link state, sync line, crc fault, sticky expiry flag
  wire [7:0] status_word = {4'h0, expired, CRC_FAULT, ~SYNC_N, EB_RELEASED};

  // unmapped indices read as zero and still acknowledge
  wire [31:0] next_dat =
      hit_vco   ? {24'h000000, vco_reg}   :
      hit_sync  ? {24'h000000, sync_reg}  :
      hit_test  ? {24'h000000, test_reg}  :
      hit_wd    ? {24'h000000, wdcfg_reg} :
      hit_ctrl  ? {24'h000000, ctrl_reg}  :
      hit_st    ? {24'h000000, status_word} :
      hit_cnt   ? wd_count[31:0]          :
                  32'h00000000;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= req;
      DAT_O <= req ? next_dat : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // reconfiguring while the link is enabled is left to software;
  // the hardware accepts the write at any time
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      vco_reg   <= RST_VCO;
      sync_reg  <= RST_SYNC;
      test_reg  <= RST_TEST;
      wdcfg_reg <= RST_WDCFG;
      ctrl_reg  <= RST_CTRL;
    end else begin
      if (wr_vco)  vco_reg   <= DAT_I[7:0];
      if (wr_sync) sync_reg  <= DAT_I[7:0];
      if (wr_test) test_reg  <= DAT_I[7:0];
      if (wr_wd)   wdcfg_reg <= DAT_I[7:0];
      if (wr_ctrl) ctrl_reg  <= DAT_I[7:0];
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  wire [TEST_W-1:0] test_code = test_reg[TEST_LSB +: TEST_W];
  // reserved test codes fall back to normal reception
  wire test_valid = (test_code <= SLWD_TEST_PRBS31);
  wire slwd_test_t next_test = test_valid ? slwd_test_t'(test_code) : SLWD_TEST_NORMAL;

  // manual request and the link's own sync line are combined; either one pulls SYNC_N low
  wire next_sync_n = sync_reg[SYNC_REQ_BIT] & LINK_SYNC_N;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SYNC_N        <= 1'b1;
      VCO_LOW_RANGE <= 1'b0;
      TEST_MODE     <= SLWD_TEST_NORMAL;
      LINK_ENABLE   <= 1'b0;
      LINK_ENCODING <= 1'b0;
    end else begin
      SYNC_N        <= next_sync_n;
      VCO_LOW_RANGE <= vco_reg[VCO_LOW_BIT];
      TEST_MODE     <= next_test;
      LINK_ENABLE   <= ctrl_reg[CTRL_EN_BIT];
      LINK_ENCODING <= ctrl_reg[CTRL_ENC_BIT];
    end
  end

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  wire [1:0] rate_code = wdcfg_reg[WD_RATE_LSB +: 2];
  wire [2:0] thr_code  = wdcfg_reg[WD_THR_LSB +: 3];
  wire       pll_opt   = wdcfg_reg[WD_PLL_BIT];

  // link counts as up while the elastic buffer is released and no crc fault is flagged
  wire link_good = EB_RELEASED & ~CRC_FAULT;

  logic [WD_W-1:0] wd_dec;
  logic [WD_W-1:0] wd_thr;
  logic            wd_on;

  always_comb begin
    unique case (rate_code)
      2'd0: wd_dec = WD_DEC_0;
      2'd1: wd_dec = WD_DEC_1;
      2'd2: wd_dec = WD_DEC_2;
      2'd3: wd_dec = WD_DEC_3;
    endcase
  end

  // code zero and the reserved codes keep the watchdog idle
  always_comb begin
    wd_on  = 1'b1;
    wd_thr = WD_THR_1;
    case (thr_code)
      3'd1: wd_thr = WD_THR_1;
      3'd2: wd_thr = WD_THR_2;
      3'd3: wd_thr = WD_THR_3;
      3'd4: wd_thr = WD_THR_4;
      default: wd_on = 1'b0;
    endcase
  end

  // the counter is sampled every cycle, so short up periods are seen
  // as well; a coarser sampler would also be acceptable
  wire             wd_run  = wd_on & LINK_ENABLE;
  wire             wd_sat  = (wd_count < wd_dec);
  wire [WD_W-1:0]  wd_down = wd_sat ? '0 : wd_count - wd_dec;
  wire [WD_W-1:0]  wd_up   = wd_count + WD_UP_STEP;
  wire [WD_W-1:0]  wd_step = link_good ? wd_down : wd_up;
  wire             wd_hit  = wd_run & (wd_count >= wd_thr);

  wire [WD_W-1:0] next_count = !wd_run ? '0 :
                               wd_hit  ? '0 : wd_step;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wd_count         <= '0;
      SERDES_RX_RESET  <= 1'b0;
      SERDES_PLL_RESET <= 1'b0;
    end else begin
      wd_count         <= next_count;
      SERDES_RX_RESET  <= wd_hit;
      SERDES_PLL_RESET <= wd_hit & pll_opt;
    end
  end

  // sticky expiry flag: a new expiry wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      expired <= 1'b0;
    end else begin
      expired <= wd_hit | (expired & ~clr_exp);
    end
  end

endmodule

`default_nettype wire

// ===== sim/slwd_sva.sv
// checker: bus handshake, sync path and watchdog reset properties
`timescale 1ns/1ps
`default_nettype none
module slwd_sva (
  input wire logic                CLK_SYS,
  input wire logic                RST,
  input wire logic                CYC_I,
  input wire logic                STB_I,
  input wire logic [31:0]         DAT_O,
  input wire logic                ACK_O,
  input wire logic                LINK_SYNC_N,
  input wire logic                SYNC_N,
  input wire slwd_pkg::slwd_test_t TEST_MODE,
  input wire logic                LINK_ENABLE,
  input wire logic                SERDES_RX_RESET,
  input wire logic                SERDES_PLL_RESET
);
  import slwd_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
    else $error("ack held too long");
  a_ack_answers_req: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acked");
  a_data_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside ack");
  a_sync_follows_link: assert property (!LINK_SYNC_N |=> !SYNC_N)
    else $error("link sync not passed on");
  a_test_mode_legal: assert property (TEST_MODE <= 5'h04)
    else $error("reserved test mode driven");
  a_pll_with_rx: assert property (SERDES_PLL_RESET |-> SERDES_RX_RESET)
    else $error("pll reset without rx reset");
  a_rx_reset_pulse: assert property (SERDES_RX_RESET |=> !SERDES_RX_RESET)
    else $error("rx reset not a pulse");
  a_disabled_quiet: assert property (!LINK_ENABLE [*2] |-> !SERDES_RX_RESET)
    else $error("expiry while disabled");
  cover property (SERDES_RX_RESET && SERDES_PLL_RESET);
  cover property (SERDES_RX_RESET && !SERDES_PLL_RESET);
  cover property (!SYNC_N && LINK_SYNC_N);
endmodule
bind slwd_top slwd_sva u_sva (.CLK_SYS, .RST, .CYC_I, .STB_I, .DAT_O, .ACK_O, .LINK_SYNC_N,
  .SYNC_N, .TEST_MODE, .LINK_ENABLE, .SERDES_RX_RESET, .SERDES_PLL_RESET);
`default_nettype wire

// ===== sim/slwd_link_model.sv
// partner: link-side stand-in for buffer release, crc fault and sync
`timescale 1ns/1ps
`default_nettype none
module slwd_link_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic up_req,
  input  wire logic crc_req,
  input  wire logic sync_req,
  output logic      eb_released,
  output logic      crc_fault,
  output logic      link_sync_n
);
  // one cycle of lag, as a real link status path would have
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {eb_released, crc_fault, link_sync_n} <= 3'h1;
    end else begin
      {eb_released, crc_fault, link_sync_n} <= {up_req, crc_req, ~sync_req};
    end
  end
endmodule
`default_nettype wire

// ===== sim/test_slwd_top.sv
// testbench: registers, sync, test select and watchdog scenarios
`timescale 1ns/1ps
`default_nettype none
module test_slwd_top;
  import slwd_pkg::*;
  logic clk_sys, rst, cyc, stb, we, up_req, crc_req, sync_req, ack, eb, crc, lsync_n;
  logic sync_n, vco, len, lenc, rx_rst, pll_rst;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, rd, c0;
  slwd_test_t tmode;
  int num_errors, n_checks;
  int dec[4] = '{1, 2, 8, 16};
  slwd_top uut (.CLK_SYS(clk_sys), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .EB_RELEASED(eb), .CRC_FAULT(crc),
    .LINK_SYNC_N(lsync_n), .SYNC_N(sync_n), .VCO_LOW_RANGE(vco), .TEST_MODE(tmode),
    .LINK_ENABLE(len), .LINK_ENCODING(lenc), .SERDES_RX_RESET(rx_rst),
    .SERDES_PLL_RESET(pll_rst));
  slwd_link_model link (.clk(clk_sys), .rst, .up_req, .crc_req, .sync_req,
    .eb_released(eb), .crc_fault(crc), .link_sync_n(lsync_n));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {cyc, stb, we, adr, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    rd = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic t_regs;
    logic [9:0] ix[5] = '{IDX_VCO, IDX_SYNC, IDX_TEST, IDX_WDCFG, 10'h3ff};
    logic [7:0] ex[5] = '{RST_VCO, RST_SYNC, RST_TEST, RST_WDCFG, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wb(0, ix[i], 0);
      chk("reset value", rd, ex[i]);
    end
    wb(1, 10'h3ff, 32'hff);
    wb(0, 10'h3ff, 0);
    chk("unmapped", rd, 0);
    wb(1, IDX_VCO, 32'hffff_ff01);
    wb(0, IDX_VCO, 0);
    chk("vco reg", rd, 32'h01);
    chk("vco pin", vco, 1);
  endtask
  task automatic t_sync;
    wb(1, IDX_CTRL, 32'h2);
    @(posedge clk_sys);
    chk("encoding pin", lenc, 1);
    wb(1, IDX_CTRL, 0);
    wb(1, IDX_SYNC, 0);
    @(posedge clk_sys);
    chk("manual sync", sync_n, 0);
    wb(1, IDX_SYNC, 1);
    @(posedge clk_sys);
    chk("sync release", sync_n, 1);
    sync_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("link sync", sync_n, 0);
    wb(0, IDX_STATUS, 0);
    chk("sync status", rd, 32'h02);
    sync_req <= 1'b0;
  endtask
  task automatic t_test;
    for (int c = 0; c < 8; c++) begin
      wb(1, IDX_TEST, c);
      @(posedge clk_sys);
      chk("test mode", tmode, c <= 4 ? c : 0);
    end
  endtask
  task automatic t_rate;
    for (int r = 0; r < 4; r++) begin
      wb(1, IDX_CTRL, 0);
      wb(1, IDX_WDCFG, {26'h0, r[1:0], 4'h4});
      wb(1, IDX_CTRL, 1);
      repeat (200) @(posedge clk_sys);
      up_req <= 1'b1;
      // the count drops by the rate step on every up cycle; stay up 1030 cycles before sampling it
      repeat (1030) @(posedge clk_sys);
      wb(0, IDX_COUNT, 0);
      c0 = rd;
      wb(0, IDX_COUNT, 0);
      chk("decrement", c0 - rd, 3 * dec[r]);
      crc_req <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wb(0, IDX_COUNT, 0);
      c0 = rd;
      wb(0, IDX_COUNT, 0);
      chk("fault step", rd - c0, 384);
      {crc_req, up_req} <= 2'b00;
    end
  endtask
  task automatic t_expire;
    int n;
    for (int p = 0; p < 2; p++) begin
      wb(1, IDX_CTRL, 0);
      wb(1, IDX_WDCFG, {24'h0, p[0], 7'h01});
      wb(1, IDX_CTRL, 1);
      n = 0;
      while (rx_rst !== 1'b1) begin
        @(posedge clk_sys);
        n++;
      end
      chk("pll reset", pll_rst, p);
      chk("link enable", len, 1);
      chk("expiry time", n > 1000 && n < 1040, 1);
      wb(0, IDX_COUNT, 0);
      chk("count cleared", rd < 32'h400, 1);
      wb(0, IDX_STATUS, 0);
      chk("expired flag", rd, 32'h08);
      wb(1, IDX_STATUS, 32'h08);
      wb(0, IDX_STATUS, 0);
      chk("expired clear", rd, 32'h00);
    end
    wb(1, IDX_CTRL, 0);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, cyc, stb, we, up_req, crc_req, sync_req} = 7'h40;
    {adr, sel, dat_i} = {10'h0, 4'hf, 32'h0};
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    chk("sync idle", sync_n, 1);
    t_regs;
    t_sync;
    t_test;
    t_rate;
    t_expire;
    finish_test;
  end
  // generous bound: the scenarios need well under 9000 cycles
  initial begin
    #200000;
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
